// ==== verification/board_fpga_gpio_bus_and_boot_properties.sv ====
// Concurrent checks on the ports of the board FPGA bus slave and boot sequencer.
`timescale 1ns/1ps
module bus_and_boot_checker
    import board_pkg::*;
#(
    parameter logic [31:0] POR_HOLD_CYCLES = 32'h0000_0014
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic warm_reset_button_n,
    input wire logic processor_reset_status_n,
    input wire board_pkg::bus_cmd_t bus_cmd,
    input wire logic bus_strobe,
    input wire logic bus_data_oe,
    input wire logic bus_ready,
    input wire logic processor_por_n,
    input wire logic processor_warm_reset_n,
    input wire logic config_pin_oe,
    input wire logic client_gpio_oe,
    input wire logic boot_mode_over
);
    logic [31:0] low_cnt_reg;
    logic [31:0] rel_cnt_reg;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Cycles that the warm reset output has been held low.
    always_ff @(posedge clk) begin
        low_cnt_reg <= (!nrst || processor_warm_reset_n) ? 32'h0000_0000 : low_cnt_reg + 32'h0000_0001;
    end
    // Cycles since warm reset release while power-on reset is still held.
    always_ff @(posedge clk) begin
        rel_cnt_reg <= (!nrst || !processor_warm_reset_n) ? 32'h0000_0000 : rel_cnt_reg + 32'h0000_0001;
    end
    property p_oe_read; bus_data_oe |-> bus_cmd == CMD_READ; endproperty
    a_oe_read: assert property (p_oe_read) else $error("shared lines driven outside a read");
    property p_oe_off; $fell(bus_strobe) |-> ##[1:4] !bus_data_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("driver still on after strobe release");
    property p_ready_rw; bus_ready |-> bus_cmd inside {CMD_READ, CMD_WRITE}; endproperty
    a_ready_rw: assert property (p_ready_rw) else $error("ready outside read or write");
    property p_quiet_boot; !boot_mode_over |-> !bus_ready && !bus_data_oe; endproperty
    a_quiet_boot: assert property (p_quiet_boot) else $error("bus answered during boot");
    property p_por_rel; $rose(processor_por_n) |-> processor_warm_reset_n &&
        rel_cnt_reg + 32'h0000_0001 >= POR_HOLD_CYCLES; endproperty
    a_por_rel: assert property (p_por_rel) else $error("power-on reset released early");
    property p_warm_hold; $rose(processor_warm_reset_n) |-> low_cnt_reg >= 32'h0000_09c3; endproperty
    a_warm_hold: assert property (p_warm_hold) else $error("warm reset pulse too short");
    property p_done; $rose(boot_mode_over) |-> processor_reset_status_n && processor_por_n &&
        !client_gpio_oe && !config_pin_oe; endproperty
    a_done: assert property (p_done) else $error("boot end signalled out of order");
    property p_button; $fell(warm_reset_button_n) && boot_mode_over |->
        ##[1:6] (!processor_warm_reset_n && processor_por_n); endproperty
    a_button: assert property (p_button) else $error("button did not start a warm reset");
endmodule : bus_and_boot_checker

// ==== verification/host_bus_model.sv ====
// Host processor model that masters the strobed register bus and drives reset status.
`timescale 1ns/1ps
module host_bus_model
    import board_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] bus_data_out,
    input wire logic bus_data_oe,
    input wire logic bus_ready,
    output board_pkg::bus_cmd_t bus_cmd,
    output logic bus_strobe,
    output logic [7:0] bus_data_in,
    output logic processor_reset_status_n
);
    logic host_drive;
    logic [7:0] host_val;
    // Released lines show the inverse of the last host value, never a stale copy.
    assign bus_data_in = bus_data_oe ? bus_data_out : (host_drive ? host_val : ~host_val);
    initial begin
        bus_cmd = CMD_NOP;
        bus_strobe = 1'b0;
        host_drive = 1'b0;
        host_val = 8'h00;
        processor_reset_status_n = 1'b0;
    end
    task automatic cycle(input bus_cmd_t cmd, input logic [7:0] val, input int slow, output logic [7:0] rd);
        int n;
        n = 0;
        rd = {8{1'bx}};
        @(posedge clk);
        #2;
        bus_cmd = cmd;
        host_drive = (cmd != CMD_READ);
        host_val = val;
        bus_strobe = 1'b1;
        repeat (3 + slow) @(posedge clk);
        while (cmd inside {CMD_READ, CMD_WRITE} && bus_ready !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        if (n < 40) rd = bus_data_in;
        #2;
        bus_strobe = 1'b0;
        host_drive = 1'b0;
        repeat (4) @(posedge clk);
    endtask : cycle
    task automatic reset_status_rise();
        @(posedge clk);
        #2;
        processor_reset_status_n = 1'b0;
        repeat (4) @(posedge clk);
        #2;
        processor_reset_status_n = 1'b1;
    endtask : reset_status_rise
endmodule : host_bus_model

// ==== verification/tb_board_fpga_gpio_bus_and_boot.sv ====
// Self-checking testbench for the board FPGA bus slave and boot sequencer.
`timescale 1ns/1ps
module tb_board_fpga_gpio_bus_and_boot;
    import board_pkg::*;
    localparam logic [7:0] BIT_VER = 8'h3c;
    localparam logic [7:0] SRC_VER = 8'h5a;
    logic clk = 1'b0, nrst, pll_locked, warm_reset_button_n, processor_reset_status_n, mode_select;
    logic user_switch_one_in, user_switch_two_in, bus_strobe, bus_data_oe, bus_ready, processor_por_n;
    logic processor_warm_reset_n, config_pin_oe, client_gpio_oe, boot_mode_over, user_led_zero, user_led_one;
    logic flash_write_protect;
    logic [15:0] config_strap_in, config_pin_out;
    logic [3:0] boot_mode_switch;
    logic [2:0] board_revision_in;
    logic [7:0] bus_data_in, bus_data_out, q;
    bus_cmd_t bus_cmd;
    int n_mismatch = 0, n_tests = 0, n;
    logic [7:0] rsvd[6] = '{8'h00, 8'h05, 8'h08, 8'h0a, 8'h21, 8'h23};
    logic [7:0] ctl[6] = '{8'h80, 8'ha0, 8'hc0, 8'he0, 8'h60, 8'h1f};
    logic [3:0] modes[4] = '{4'h2, 4'h6, 4'h7, 4'h8};
    always #10 clk = ~clk;
    board_fpga_gpio_bus_and_boot #(.BITSTREAM_VERSION(BIT_VER), .DESIGN_VERSION(SRC_VER),
        .POR_HOLD_CYCLES(32'h0000_0014), .NET_BOOT_WAIT_CYCLES(32'h0000_001e)) board_fpga_gpio_bus_and_boot_inst (
        .clk(clk), .nrst(nrst), .pll_locked(pll_locked), .warm_reset_button_n(warm_reset_button_n),
        .config_strap_in(config_strap_in), .boot_mode_switch(boot_mode_switch), .mode_select(mode_select),
        .processor_reset_status_n(processor_reset_status_n), .bus_cmd(bus_cmd), .bus_strobe(bus_strobe),
        .bus_data_in(bus_data_in), .user_switch_one_in(user_switch_one_in), .user_switch_two_in(user_switch_two_in),
        .board_revision_in(board_revision_in), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
        .bus_ready(bus_ready), .processor_por_n(processor_por_n), .processor_warm_reset_n(processor_warm_reset_n),
        .config_pin_out(config_pin_out), .config_pin_oe(config_pin_oe), .client_gpio_oe(client_gpio_oe),
        .boot_mode_over(boot_mode_over), .user_led_zero(user_led_zero), .user_led_one(user_led_one),
        .flash_write_protect(flash_write_protect));
    host_bus_model host_bus_model_inst (.clk(clk), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
        .bus_ready(bus_ready), .bus_cmd(bus_cmd), .bus_strobe(bus_strobe), .bus_data_in(bus_data_in),
        .processor_reset_status_n(processor_reset_status_n));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_for(ref logic sig, input logic val, input int lim);
        n = 0;
        while (sig !== val && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk({15'h0000, sig}, {15'h0000, val});
    endtask : wait_for
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host_bus_model_inst.cycle(CMD_ADDR, a, 0, q);
        host_bus_model_inst.cycle(CMD_READ, 8'h00, 1, q);
        chk({8'h00, q}, {8'h00, e});
    endtask : rd_chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_bus_model_inst.cycle(CMD_ADDR, a, 0, q);
        host_bus_model_inst.cycle(CMD_WRITE, d, 2, q);
    endtask : wr
    task automatic cold_boot(input logic net);
        #2;
        nrst = 1'b0;
        pll_locked = 1'b0;
        repeat (16) @(posedge clk);
        #2;
        chk({8'h00, processor_por_n, processor_warm_reset_n, boot_mode_over, client_gpio_oe, user_led_zero,
            user_led_one, flash_write_protect, config_pin_oe}, 16'h001c);
        nrst = 1'b1;
        repeat (3) @(posedge clk);
        #2;
        pll_locked = 1'b1;
        wait_for(config_pin_oe, 1'b1, 20);
        chk(config_pin_out, config_strap_in);
        wait_for(processor_warm_reset_n, 1'b1, 3000);
        chk({15'h0000, processor_por_n}, 16'h0000);
        wait_for(processor_por_n, 1'b1, 100);
        host_bus_model_inst.reset_status_rise();
        if (net) begin
            wait_for(processor_warm_reset_n, 1'b0, 100);
            wait_for(processor_warm_reset_n, 1'b1, 3000);
            chk({15'h0000, n >= 2499 && n <= 2501}, 16'h0001);
        end
        wait_for(boot_mode_over, 1'b1, 10);
        chk({14'h0000, client_gpio_oe, processor_warm_reset_n}, 16'h0001);
        $display("cold boot with mode %h done", boot_mode_switch);
    endtask : cold_boot
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test
    initial begin
        {warm_reset_button_n, mode_select, user_switch_one_in, user_switch_two_in} = 4'b1010;
        config_strap_in = 16'ha5c3;
        board_revision_in = 3'h5;
        foreach (modes[i]) begin
            boot_mode_switch = modes[i];
            cold_boot(modes[i] inside {4'h6, 4'h7, 4'h8});
        end
        rd_chk(8'h09, 8'h70);
        rd_chk(8'h06, BIT_VER);
        rd_chk(8'h07, SRC_VER);
        rd_chk(8'h22, 8'ha1);
        wr(8'h06, 8'h00);
        rd_chk(8'h06, BIT_VER);
        foreach (rsvd[i]) begin
            wr(rsvd[i], 8'hff);
            rd_chk(rsvd[i], 8'h00);
        end
        wr(8'h09, 8'h0f);
        host_bus_model_inst.cycle(CMD_NOP, 8'h22, 0, q);
        foreach (ctl[i]) begin
            host_bus_model_inst.cycle(CMD_WRITE, ctl[i], 0, q);
            host_bus_model_inst.cycle(CMD_READ, 8'h00, 0, q);
            chk({8'h00, q}, {8'h00, ctl[i] & 8'hf0});
            chk({14'h0000, user_led_one, user_led_zero}, {14'h0000, ctl[i][7] ? ctl[i][6:5] : 2'b11});
        end
        $display("register test done");
        #2;
        mode_select = 1'b1;
        host_bus_model_inst.cycle(CMD_WRITE, 8'h00, 0, q);
        chk({15'h0000, flash_write_protect}, 16'h0001);
        #2;
        mode_select = 1'b0;
        rd_chk(8'h09, 8'h10);
        chk({15'h0000, flash_write_protect}, 16'h0000);
        $display("pass-through test done");
        #2;
        config_strap_in = 16'h3c5a;
        warm_reset_button_n = 1'b0;
        wait_for(processor_warm_reset_n, 1'b0, 10);
        #2;
        warm_reset_button_n = 1'b1;
        chk({14'h0000, processor_por_n, boot_mode_over}, 16'h0002);
        wait_for(processor_warm_reset_n, 1'b1, 3000);
        chk(config_pin_out, 16'h3c5a);
        host_bus_model_inst.reset_status_rise();
        wait_for(boot_mode_over, 1'b1, 10);
        chk({14'h0000, processor_por_n, processor_warm_reset_n}, 16'h0003);
        $display("warm boot test done");
        end_of_test();
    end
    initial begin
        #800000;
        n_mismatch++;
        end_of_test();
    end
endmodule : tb_board_fpga_gpio_bus_and_boot
bind board_fpga_gpio_bus_and_boot bus_and_boot_checker #(.POR_HOLD_CYCLES(POR_HOLD_CYCLES)) bus_and_boot_checker_inst (
    .clk(clk), .nrst(nrst), .warm_reset_button_n(warm_reset_button_n), .bus_cmd(bus_cmd),
    .processor_reset_status_n(processor_reset_status_n), .bus_strobe(bus_strobe), .bus_data_oe(bus_data_oe),
    .bus_ready(bus_ready), .processor_por_n(processor_por_n), .processor_warm_reset_n(processor_warm_reset_n),
    .config_pin_oe(config_pin_oe), .client_gpio_oe(client_gpio_oe), .boot_mode_over(boot_mode_over));

// ==== verilog/board_fpga_gpio_bus_and_boot.sv ====
// Board FPGA: strobed 8-bit bus slave, configuration registers and reset/boot sequencer.
`timescale 1ns/1ps
`include "board_params.svh"

module board_fpga_gpio_bus_and_boot #(
    parameter int STRAP_WIDTH = 16,
    // Arbitrary version values.
    parameter logic [7:0] BITSTREAM_VERSION = 8'h3c,
    parameter logic [7:0] DESIGN_VERSION = 8'h5a,
    parameter logic [31:0] POR_HOLD_CYCLES = 32'(`POR_HOLD_MS * `CLK_FREQ_KHZ),
    parameter logic [31:0] NET_BOOT_WAIT_CYCLES = 32'(`NET_BOOT_WAIT_MS * `CLK_FREQ_KHZ)
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic pll_locked,
    input wire logic warm_reset_button_n,
    input wire logic [STRAP_WIDTH-1:0] config_strap_in,
    input wire logic [3:0] boot_mode_switch,
    input wire logic processor_reset_status_n,
    input wire logic mode_select,
    input wire board_pkg::bus_cmd_t bus_cmd,
    input wire logic bus_strobe,
    input wire logic [7:0] bus_data_in,
    input wire logic user_switch_one_in,
    input wire logic user_switch_two_in,
    input wire logic [2:0] board_revision_in,
    output logic [7:0] bus_data_out,
    output logic bus_data_oe,
    output logic bus_ready,
    output logic processor_por_n,
    output logic processor_warm_reset_n,
    output logic [STRAP_WIDTH-1:0] config_pin_out,
    output logic config_pin_oe,
    output logic client_gpio_oe,
    output logic boot_mode_over,
    output logic user_led_zero,
    output logic user_led_one,
    output logic flash_write_protect
);
    import board_pkg::*;

    localparam logic [31:0] WARM_HOLD_CYCLES = 32'((`WARM_HOLD_US * `CLK_FREQ_KHZ + `US_PER_MS - 1) / `US_PER_MS);

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    logic pll_meta_reg, pll_sync_reg;
    logic button_meta_reg, button_sync_reg;
    logic status_meta_reg, status_sync_reg;
    logic mode_meta_reg, mode_sync_reg;
    logic strobe_meta_reg, strobe_sync_reg;
    logic [1:0] cmd_meta_reg, cmd_sync_reg;
    logic [7:0] data_meta_reg, data_sync_reg;
    logic [STRAP_WIDTH-1:0] strap_meta_reg, strap_sync_reg;
    logic [3:0] bootsw_meta_reg, bootsw_sync_reg;
    logic [1:0] sw_meta_reg, sw_sync_reg;
    logic [2:0] rev_meta_reg, rev_sync_reg;

    // Stages track their pins through reset, so idle levels are in place when reset ends.
    always_ff @(posedge clk) begin
        pll_meta_reg <= pll_locked;
        pll_sync_reg <= pll_meta_reg;
        button_meta_reg <= warm_reset_button_n;
        button_sync_reg <= button_meta_reg;
        status_meta_reg <= processor_reset_status_n;
        status_sync_reg <= status_meta_reg;
        mode_meta_reg <= mode_select;
        mode_sync_reg <= mode_meta_reg;
        strobe_meta_reg <= bus_strobe;
        strobe_sync_reg <= strobe_meta_reg;
        cmd_meta_reg <= bus_cmd;
        cmd_sync_reg <= cmd_meta_reg;
        data_meta_reg <= bus_data_in;
        data_sync_reg <= data_meta_reg;
        strap_meta_reg <= config_strap_in;
        strap_sync_reg <= strap_meta_reg;
        bootsw_meta_reg <= boot_mode_switch;
        bootsw_sync_reg <= bootsw_meta_reg;
        sw_meta_reg <= {user_switch_two_in, user_switch_one_in};
        sw_sync_reg <= sw_meta_reg;
        rev_meta_reg <= board_revision_in;
        rev_sync_reg <= rev_meta_reg;
    end

    // ------------------------------------------------------------------------
    // Edge detection on synchronised levels
    // ------------------------------------------------------------------------
    logic strobe_prev_reg, status_prev_reg, button_prev_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            strobe_prev_reg <= 1'b0;
            status_prev_reg <= 1'b1;
            button_prev_reg <= 1'b0;
        end else begin
            strobe_prev_reg <= strobe_sync_reg;
            status_prev_reg <= status_sync_reg;
            button_prev_reg <= button_sync_reg;
        end
    end

    logic strobe_rise, status_rise, button_press;
    assign strobe_rise = strobe_sync_reg && !strobe_prev_reg;
    assign status_rise = status_sync_reg && !status_prev_reg;
    assign button_press = button_prev_reg && !button_sync_reg;

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------
    function automatic logic count_done(input logic [31:0] count, input logic [31:0] limit);
        count_done = (count + `COUNT_ONE >= limit);
    endfunction : count_done

    function automatic logic is_net_boot(input logic [3:0] code);
        is_net_boot = (code == `NET_BOOT_CODE_A) || (code == `NET_BOOT_CODE_B) || (code == `NET_BOOT_CODE_C);
    endfunction : is_net_boot

    // ------------------------------------------------------------------------
    // Boot sequencer
    // ------------------------------------------------------------------------
    boot_state_t state_reg;
    logic [31:0] count_reg;
    logic cold_reg;
    logic [3:0] boot_code_reg;
    logic por_reg, warm_reg, config_oe_reg, client_oe_reg, boot_over_reg;
    logic [STRAP_WIDTH-1:0] config_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= ST_WAIT_PLL;
            count_reg <= `COUNT_ZERO;
            cold_reg <= 1'b1;
            boot_code_reg <= '0;
            config_reg <= '0;
            por_reg <= 1'b0;
            warm_reg <= 1'b0;
            config_oe_reg <= 1'b0;
            client_oe_reg <= 1'b1;
            boot_over_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_WAIT_PLL: begin
                    count_reg <= `COUNT_ZERO;
                    if (pll_sync_reg) begin
                        state_reg <= ST_LATCH;
                    end
                end
                ST_LATCH: begin
                    config_reg <= strap_sync_reg;
                    boot_code_reg <= bootsw_sync_reg;
                    config_oe_reg <= 1'b1;
                    state_reg <= ST_HOLD_WARM;
                end
                ST_HOLD_WARM: begin
                    count_reg <= count_reg + `COUNT_ONE;
                    if (count_done(count_reg, WARM_HOLD_CYCLES)) begin
                        warm_reg <= 1'b1;
                        count_reg <= `COUNT_ZERO;
                        state_reg <= cold_reg ? ST_HOLD_POR : ST_WAIT_STATUS;
                    end
                end
                ST_HOLD_POR: begin
                    count_reg <= count_reg + `COUNT_ONE;
                    if (count_done(count_reg, POR_HOLD_CYCLES)) begin
                        por_reg <= 1'b1;
                        count_reg <= `COUNT_ZERO;
                        state_reg <= ST_WAIT_STATUS;
                    end
                end
                ST_WAIT_STATUS: begin
                    if (status_rise) begin
                        client_oe_reg <= 1'b0;
                        config_oe_reg <= 1'b0;
                        if (cold_reg && is_net_boot(boot_code_reg)) begin
                            state_reg <= ST_NET_WAIT;
                        end else begin
                            boot_over_reg <= 1'b1;
                            state_reg <= ST_DONE;
                        end
                    end
                end
                ST_NET_WAIT: begin
                    count_reg <= count_reg + `COUNT_ONE;
                    if (count_done(count_reg, NET_BOOT_WAIT_CYCLES)) begin
                        warm_reg <= 1'b0;
                        count_reg <= `COUNT_ZERO;
                        state_reg <= ST_NET_PULSE;
                    end
                end
                ST_NET_PULSE: begin
                    count_reg <= count_reg + `COUNT_ONE;
                    if (count_done(count_reg, WARM_HOLD_CYCLES)) begin
                        warm_reg <= 1'b1;
                        count_reg <= `COUNT_ZERO;
                        boot_over_reg <= 1'b1;
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    count_reg <= `COUNT_ZERO;
                end
                default: begin
                    state_reg <= ST_WAIT_PLL;
                    count_reg <= `COUNT_ZERO;
                end
            endcase
            // A warm restart is only honoured once power-on reset has been released.
            if (button_press && por_reg) begin
                state_reg <= ST_WAIT_PLL;
                count_reg <= `COUNT_ZERO;
                cold_reg <= 1'b0;
                warm_reg <= 1'b0;
                client_oe_reg <= 1'b1;
                boot_over_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Bus slave cycle decode
    // ------------------------------------------------------------------------
    logic bus_enable;
    logic [7:0] addr_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] status_reg;
    logic read_active_reg, write_active_reg;
    logic [7:0] data_out_reg;
    logic data_oe_reg, ready_reg;

    // The bus answers only after boot and outside pass-through mode.
    assign bus_enable = boot_over_reg && !mode_sync_reg;

    function automatic logic [7:0] read_value(input logic [7:0] addr, input logic [7:0] ctrl, input logic [7:0] status);
        case (addr)
            `REG_ADDR_BITSTREAM_VERSION: read_value = BITSTREAM_VERSION;
            `REG_ADDR_DESIGN_VERSION: read_value = DESIGN_VERSION;
            `REG_ADDR_CONTROL: read_value = ctrl;
            `REG_ADDR_SWITCH_STATUS: read_value = status;
            default: read_value = `READ_ZERO;
        endcase
    endfunction : read_value

    always_ff @(posedge clk) begin
        if (!nrst) begin
            addr_reg <= `ADDR_RESET;
        end else if (strobe_rise && bus_enable && cmd_sync_reg == CMD_ADDR) begin
            addr_reg <= data_sync_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_reg <= `CONTROL_RESET;
        end else if (strobe_rise && bus_enable && cmd_sync_reg == CMD_WRITE &&
                     addr_reg == `REG_ADDR_CONTROL) begin
            ctrl_reg <= data_sync_reg & `CONTROL_WRITABLE_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            status_reg <= `STATUS_RESET;
        end else begin
            status_reg <= {rev_sync_reg, `STATUS_RSVD_ZERO, sw_sync_reg};
        end
    end

    // A cycle stays active until the strobe drops; idle gaps need no command.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            read_active_reg <= 1'b0;
            write_active_reg <= 1'b0;
        end else if (!strobe_sync_reg) begin
            read_active_reg <= 1'b0;
            write_active_reg <= 1'b0;
        end else if (strobe_rise && bus_enable) begin
            read_active_reg <= (cmd_sync_reg == CMD_READ);
            write_active_reg <= (cmd_sync_reg == CMD_WRITE);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            data_out_reg <= `READ_ZERO;
        end else if (strobe_rise && bus_enable && cmd_sync_reg == CMD_READ) begin
            data_out_reg <= read_value(addr_reg, ctrl_reg, status_reg);
        end
    end

    // Drivers turn on one cycle after the read is taken, off as soon as strobe drops.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            data_oe_reg <= 1'b0;
        end else begin
            data_oe_reg <= read_active_reg && strobe_sync_reg && bus_enable &&
                           cmd_sync_reg == CMD_READ;
        end
    end

    // Ready rises only after data is on the lines, so the host never samples stale data.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= strobe_sync_reg && (data_oe_reg || write_active_reg);
        end
    end

    // ------------------------------------------------------------------------
    // LED and flash write-protect outputs
    // ------------------------------------------------------------------------
    logic led0_reg, led1_reg, wp_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            led0_reg <= `LED_OFF_LEVEL;
            led1_reg <= `LED_OFF_LEVEL;
            wp_reg <= `WP_IDLE_LEVEL;
        end else begin
            led0_reg <= ctrl_reg[`CTRL_LED_EN_BIT] ? ctrl_reg[`CTRL_LED0_BIT] : `LED_OFF_LEVEL;
            led1_reg <= ctrl_reg[`CTRL_LED_EN_BIT] ? ctrl_reg[`CTRL_LED1_BIT] : `LED_OFF_LEVEL;
            wp_reg <= mode_sync_reg ? ctrl_reg[`CTRL_WP_BIT] : `WP_IDLE_LEVEL;
        end
    end

    // ------------------------------------------------------------------------
    // Output assignments
    // ------------------------------------------------------------------------
    assign bus_data_out = data_out_reg;
    assign bus_data_oe = data_oe_reg;
    assign bus_ready = ready_reg;
    assign processor_por_n = por_reg;
    assign processor_warm_reset_n = warm_reg;
    assign config_pin_out = config_reg;
    assign config_pin_oe = config_oe_reg;
    assign client_gpio_oe = client_oe_reg;
    assign boot_mode_over = boot_over_reg;
    assign user_led_zero = led0_reg;
    assign user_led_one = led1_reg;
    assign flash_write_protect = wp_reg;

endmodule : board_fpga_gpio_bus_and_boot

// ==== verilog/board_params.svh ====
// Named constants for the board FPGA bus slave, register file and boot sequencer.
`ifndef BOARD_PARAMS_SVH
`define BOARD_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define REG_ADDR_BITSTREAM_VERSION 8'h06
`define REG_ADDR_DESIGN_VERSION 8'h07
`define REG_ADDR_RESERVED_SLOT 8'h08
`define REG_ADDR_CONTROL 8'h09
`define REG_ADDR_SWITCH_STATUS 8'h22

// ----------------------------------------------------------------------------
// Register fields and reset values
// ----------------------------------------------------------------------------
`define CONTROL_RESET 8'h70
`define CONTROL_WRITABLE_MASK 8'hf0
`define CTRL_WP_BIT 4
`define CTRL_LED0_BIT 5
`define CTRL_LED1_BIT 6
`define CTRL_LED_EN_BIT 7
`define STATUS_RESET 8'h00
`define STATUS_RSVD_ZERO 3'h0
`define READ_ZERO 8'h00
`define ADDR_RESET 8'h00
`define LED_OFF_LEVEL 1'b1
`define WP_IDLE_LEVEL 1'b0

// ----------------------------------------------------------------------------
// Boot mode codes that select a network boot
// ----------------------------------------------------------------------------
`define NET_BOOT_CODE_A 4'h6
`define NET_BOOT_CODE_B 4'h7
`define NET_BOOT_CODE_C 4'h8

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_FREQ_KHZ 50000
`define US_PER_MS 1000
`define WARM_HOLD_US 50
`define POR_HOLD_MS 200
`define NET_BOOT_WAIT_MS 4000
`define COUNT_ZERO 32'h0000_0000
`define COUNT_ONE 32'h0000_0001

`endif

// ==== verilog/board_pkg.sv ====
// Types shared by the board FPGA bus slave and boot sequencer.
package board_pkg;

    // ------------------------------------------------------------------------
    // Bus command encoding
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_NOP = 2'h0,
        CMD_ADDR = 2'h1,
        CMD_READ = 2'h2,
        CMD_WRITE = 2'h3
    } bus_cmd_t;

    // ------------------------------------------------------------------------
    // Boot sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_WAIT_PLL = 8'h01,
        ST_LATCH = 8'h02,
        ST_HOLD_WARM = 8'h04,
        ST_HOLD_POR = 8'h08,
        ST_WAIT_STATUS = 8'h10,
        ST_NET_WAIT = 8'h20,
        ST_NET_PULSE = 8'h40,
        ST_DONE = 8'h80
    } boot_state_t;

endpackage : board_pkg
